// *** rtl/csctl_top.sv ***
// Clock source selection, start-up timing and peripheral clock gating
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
module csctl_top #(
  parameter int POWER_UP_WAIT_TIMER_CYC      = 1000,
  parameter int INT_START_CYC = 20,
  parameter int MULT_CYC      = csctl_pkg::MULT_LOCK_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  osc_input_pin,
  input  wire logic                  wake_pin,
  input  wire logic                  brownout_pin,
  input  wire logic                  sleep_req,
  output logic                       exec_hold,
  output logic                       sysclk_run,
  output csctl_pkg::csctl_src_t      run_source,
  output logic [1:0]                 ext_power_level,
  output logic                       osc_output_gpio_en,
  output logic [7:0]                 periph_clk_en
);
  import csctl_pkg::*;

  localparam int TW = 24;

  // Refuse power-up and multiplier figures that the wait counters cannot hold, and any figure below 1
  if (POWER_UP_WAIT_TIMER_CYC < 1 || INT_START_CYC < 1 || MULT_CYC < 1 ||
      MULT_CYC >= (1 << TW) || POWER_UP_WAIT_TIMER_CYC >= (1 << TW)) begin : g_param_chk
    $error("csctl_top: timing parameter out of range");
  end

  logic [11:0]  ctrl_q;
  logic [7:0]   pdis_q;
  logic [31:0]  prdata_q;
  logic [2:0]   osc_sync_q;
  logic [2:0]   wake_sync_q;
  logic [2:0]   bor_sync_q;
  csctl_state_t state_q;
  csctl_src_t   active_q;
  csctl_src_t   target_q;
  logic         boot_q;
  logic         twospd_q;
  logic [10:0]  edge_cnt_q;
  logic [10:0]  edge_tgt_q;
  logic [TW-1:0] time_cnt_q;
  logic [TW-1:0] time_tgt_q;
  csctl_src_t   want_src;
  logic         osc_rise;
  logic         wake_rise;
  logic         bor_rise;
  logic         load_seq;
  logic         load_boot;
  logic         edge_done;
  logic         time_done;
  logic         power_up_wait_timer_done;
  logic         wr_en;
  logic         rd_en;
  logic         mapped;

  // Map the choice field and config field onto an oscillator kind
  function automatic csctl_src_t pick_src(input logic [11:0] c);
    logic [3:0] cfg;
    cfg = c[CFG_LSB +: 4];
    case (c[CHOICE_LSB +: 2])
      2'b00: begin
        if (cfg <= CFG_HS_XTAL) pick_src = SRC_XTAL;
        else if (cfg <= CFG_EC_HIGH) pick_src = SRC_EXT;
        else pick_src = SRC_FAST;
      end
      2'b01: pick_src = SRC_SLOW;
      default: pick_src = c[FASTSEL_BIT] ? SRC_FAST : SRC_MED;
    endcase
  endfunction

  // Oscillations of the input pin to wait for a given move
  function automatic logic [10:0] edge_need(input csctl_src_t from,
                                            input csctl_src_t to,
                                            input logic boot);
    case (to)
      SRC_XTAL: edge_need = 11'(OST_EDGES);
      SRC_EXT: begin
        if (!boot && from == SRC_SLOW) edge_need = 11'h001;
        else edge_need = 11'(INSTR_EDGES);
      end
      default: edge_need = 11'h000;
    endcase
  endfunction

  // Clock cycles to wait after the oscillations
  function automatic logic [TW-1:0] time_need(input csctl_src_t from,
                                              input csctl_src_t to,
                                              input logic boot,
                                              input logic mult);
    case (to)
      SRC_XTAL: time_need = mult ? TW'(MULT_CYC) : '0;
      SRC_EXT: begin
        if (!boot && from == SRC_SLOW) time_need = TW'(SLOW_PER_CYC);
        else time_need = '0;
      end
      default: begin
        if (!boot && from == SRC_SLOW) time_need = TW'(SWITCH_CYC);
        else time_need = TW'(INT_START_CYC);
      end
    endcase
  endfunction

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign mapped = (paddr == OSC_CTRL_OFS) || (paddr == PERIPH_DIS_OFS) ||
                  (paddr == STATUS_OFS);
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // Read data is captured in the setup phase so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        OSC_CTRL_OFS:   prdata_q <= {20'h00000, ctrl_q};
        PERIPH_DIS_OFS: prdata_q <= {24'h000000, pdis_q};
        STATUS_OFS:     prdata_q <= {24'h000000, state_q == ST_RUN,
                                     state_q, exec_hold, active_q};
        default:        prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= OSC_CTRL_RST;
      pdis_q <= PERIPH_DIS_RST;
    end else if (wr_en) begin
      if (paddr == OSC_CTRL_OFS) ctrl_q <= pwdata[11:0] & 12'hF3F;
      if (paddr == PERIPH_DIS_OFS) pdis_q <= pwdata[7:0] & 8'hDF;
    end
  end

  // Pin synchronisers; only the second stage and later are looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_q  <= 3'h0;
      wake_sync_q <= 3'h0;
      bor_sync_q  <= 3'h0;
    end else begin
      osc_sync_q  <= {osc_sync_q[1:0], osc_input_pin};
      wake_sync_q <= {wake_sync_q[1:0], wake_pin};
      bor_sync_q  <= {bor_sync_q[1:0], brownout_pin};
    end
  end

  assign osc_rise  = osc_sync_q[1] && !osc_sync_q[2];
  assign wake_rise = wake_sync_q[1] && !wake_sync_q[2];
  assign bor_rise  = bor_sync_q[1] && !bor_sync_q[2];
  assign want_src  = pick_src(ctrl_q);
  assign edge_done = edge_cnt_q >= edge_tgt_q;
  assign time_done = time_cnt_q >= time_tgt_q;
  assign power_up_wait_timer_done = !ctrl_q[POWER_UP_WAIT_TIMER_BIT] || time_cnt_q >= TW'(POWER_UP_WAIT_TIMER_CYC);

  // A new wait sequence starts at timer expiry, wake, or source change
  always_comb begin
    load_seq  = 1'b0;
    load_boot = 1'b0;
    case (state_q)
      ST_POWER_UP_WAIT_TIMER: begin
        load_seq  = power_up_wait_timer_done;
        load_boot = 1'b1;
      end
      ST_SLEEP: begin
        load_seq  = wake_rise;
        load_boot = 1'b1;
      end
      ST_RUN: load_seq = !sleep_req && want_src != active_q;
      default: load_seq = 1'b0;
    endcase
    if (bor_rise) load_seq = 1'b0;
  end

  // Sequencer; a brown-out restarts it like a power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_POWER_UP_WAIT_TIMER;
      active_q   <= SRC_FAST;
      target_q   <= SRC_FAST;
      boot_q     <= 1'b1;
      twospd_q   <= 1'b0;
      edge_tgt_q <= 11'h000;
      time_tgt_q <= '0;
    end else if (bor_rise) begin
      state_q  <= ST_POWER_UP_WAIT_TIMER;
      twospd_q <= 1'b0;
    end else if (load_seq) begin
      state_q    <= ST_EDGE;
      target_q   <= want_src;
      boot_q     <= load_boot;
      edge_tgt_q <= edge_need(active_q, want_src, load_boot);
      time_tgt_q <= time_need(active_q, want_src, load_boot,
                              ctrl_q[MULT_BIT]);
      // Run code from the fast oscillator while the crystal settles
      twospd_q   <= load_boot && want_src == SRC_XTAL &&
                    ctrl_q[TWOSPD_BIT];
    end else begin
      case (state_q)
        ST_EDGE: if (edge_done) state_q <= ST_TIME;
        ST_TIME: begin
          if (time_done) begin
            state_q  <= ST_RUN;
            active_q <= target_q;
            twospd_q <= 1'b0;
          end
        end
        ST_RUN: if (sleep_req) state_q <= ST_SLEEP;
        default: state_q <= state_q;
      endcase
    end
  end

  // Counters; both clear whenever a new wait begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_q <= 11'h000;
      time_cnt_q <= '0;
    end else if (bor_rise || load_seq) begin
      edge_cnt_q <= 11'h000;
      time_cnt_q <= '0;
    end else begin
      if (state_q == ST_EDGE && osc_rise && !edge_done)
        edge_cnt_q <= edge_cnt_q + 11'h001;
      if (state_q == ST_EDGE)
        time_cnt_q <= '0;
      else if ((state_q == ST_POWER_UP_WAIT_TIMER || state_q == ST_TIME) &&
               time_cnt_q != '1)
        time_cnt_q <= time_cnt_q + TW'(1);
    end
  end

  // Core is held during every wait unless two-speed start-up covers it
  assign exec_hold  = state_q != ST_RUN && !twospd_q;
  assign sysclk_run = state_q != ST_SLEEP && state_q != ST_POWER_UP_WAIT_TIMER;
  // Gating only; a stopped external clock stops the core and loses nothing
  assign run_source = twospd_q ? SRC_FAST : active_q;
  assign osc_output_gpio_en = active_q == SRC_EXT;
  assign periph_clk_en = ~pdis_q & 8'hDF;

  // Drive strength follows the config field
  always_comb begin
    case (ctrl_q[CFG_LSB +: 4])
      CFG_LP_XTAL, CFG_EC_LOW: ext_power_level = 2'h0;
      CFG_XT_XTAL, CFG_EC_MED, CFG_RC: ext_power_level = 2'h1;
      default: ext_power_level = 2'h2;
    endcase
  end

  a_hold_counting: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_EDGE && !twospd_q |-> exec_hold)
    else $error("core not held during start-up wait");
  a_run_free: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_TIME && time_done && !bor_rise |=> !exec_hold)
    else $error("core still held after the wait ended");
  a_xtal_count: assert property (@(posedge pclk) disable iff (!presetn)
    load_seq && want_src == SRC_XTAL |=> edge_tgt_q == 11'h400)
    else $error("crystal wait is not 1024 oscillations");
  a_ext_no_ost: assert property (@(posedge pclk) disable iff (!presetn)
    load_seq && load_boot && want_src == SRC_EXT
    |=> edge_tgt_q == 11'h008 && time_tgt_q == '0)
    else $error("EC/RC boot delay wrong");
  a_mult_wait: assert property (@(posedge pclk) disable iff (!presetn)
    load_seq && want_src == SRC_XTAL && ctrl_q[MULT_BIT]
    |=> time_tgt_q == TW'(MULT_CYC))
    else $error("multiplier lock wait missing");
  a_slow_switch: assert property (@(posedge pclk) disable iff (!presetn)
    load_seq && !load_boot && active_q == SRC_SLOW &&
    (want_src == SRC_FAST || want_src == SRC_MED)
    |=> time_tgt_q == TW'(SWITCH_CYC) && edge_tgt_q == 11'h000)
    else $error("slow to internal switch delay wrong");
  a_count_restart: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == ST_EDGE) |-> edge_cnt_q == 11'h000)
    else $error("start-up count did not restart");
  a_ost_release: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_EDGE ##1 state_q == ST_TIME
    |-> $past(edge_cnt_q) >= $past(edge_tgt_q))
    else $error("released before full count");
  a_unused_bit: assert property (@(posedge pclk) disable iff (!presetn)
    pdis_q[PERIPH_UNUSED_BIT] == 1'b0 && !periph_clk_en[5])
    else $error("unimplemented disable bit set");
  a_periph_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == PERIPH_DIS_OFS && pwdata[7]
    |=> !periph_clk_en[7])
    else $error("disabled peripheral still clocked");
  c_xtal_boot: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_TIME ##1 state_q == ST_RUN && active_q == SRC_XTAL);
  c_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SLEEP ##1 state_q == ST_EDGE);
  c_two_speed: cover property (@(posedge pclk) disable iff (!presetn)
    twospd_q && state_q == ST_EDGE);
endmodule

// *** inc/csctl_pkg.sv ***
// Constants, register map and types of the clock source start-up control
// Operation
// - Three internal oscillators: 16M, 500k, 31.25k
// - Two-bit choice selects external or internal
// - Crystal modes count 1024 input oscillations
// - Count after reset/timer, and Sleep wake
// - Execution held while start-up count runs
// - Every source change waits a stabilisation delay
// - Optional two-speed start-up hides crystal wait
// - Boot into EC/RC costs 2 instruction cycles
// - Slow oscillator to EC/RC: one each cycle
// - Multiplier start: 1024 cycles plus 2 ms
// - Slow to other internal: about 1 us
// - EC takes input pin, frees output pin
// - Config field picks EC low/medium/high power
// - EC mode disables the 1024 count
// - Static logic: stopped clock retains state
package csctl_pkg;
  localparam logic [11:0] OSC_CTRL_OFS  = 12'h000;
  localparam logic [11:0] PERIPH_DIS_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS    = 12'h008;
  // Oscillator control fields
  localparam int          CHOICE_LSB = 0;
  localparam int          FASTSEL_BIT = 2;
  localparam int          TWOSPD_BIT = 3;
  localparam int          MULT_BIT   = 4;
  localparam int          POWER_UP_WAIT_TIMER_BIT   = 5;
  localparam int          CFG_LSB    = 8;
  localparam logic [11:0] OSC_CTRL_RST = 12'h224;
  localparam logic [7:0]  PERIPH_DIS_RST = 8'h00;
  localparam int          PERIPH_UNUSED_BIT = 5;
  // osc_config_field encodings
  localparam logic [3:0]  CFG_LP_XTAL = 4'h0;
  localparam logic [3:0]  CFG_XT_XTAL = 4'h1;
  localparam logic [3:0]  CFG_HS_XTAL = 4'h2;
  localparam logic [3:0]  CFG_RC      = 4'h3;
  localparam logic [3:0]  CFG_EC_LOW  = 4'h4;
  localparam logic [3:0]  CFG_EC_MED  = 4'h5;
  localparam logic [3:0]  CFG_EC_HIGH = 4'h6;
  // Timing
  localparam int          CLK_NS      = 100;
  localparam int          OST_EDGES   = 1024;
  localparam int          INSTR_EDGES = 8;   // 2 instruction cycles x 4
  localparam int          MULT_LOCK_NS = 2000000;
  localparam int          MULT_LOCK_CYC = (MULT_LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SWITCH_NS   = 1000;
  localparam int          SWITCH_CYC  = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SLOW_PER_NS = 32000;
  localparam int          SLOW_PER_CYC = (SLOW_PER_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    SRC_XTAL = 3'h0, SRC_EXT = 3'h1, SRC_FAST = 3'h2,
    SRC_MED  = 3'h3, SRC_SLOW = 3'h4
  } csctl_src_t;
  typedef enum logic [2:0] {
    ST_POWER_UP_WAIT_TIMER = 3'h0, ST_EDGE = 3'h1, ST_TIME = 3'h2,
    ST_RUN  = 3'h3, ST_SLEEP = 3'h4
  } csctl_state_t;
endpackage

// *** bench/csctl_osc_model.sv ***
// Behavioural external crystal or clock feeding the oscillator input pin
`timescale 1ns/10ps
module csctl_osc_model (
  input  wire logic run,
  input  wire logic slow,
  output logic      osc,
  output int        rises
);
  // Prompt 2.5 MHz sits in the medium band, slow 250 kHz below 500 kHz
  int half_ns;
  assign half_ns = slow ? 2000 : 200;
  // A stopped source stands low, so the pin shows no stale activity
  initial begin
    osc = 1'b0;
    forever begin
      if (run) begin
        #(half_ns) osc = ~osc;
      end else begin
        osc = 1'b0;
        #25;
      end
    end
  end
  // Tally of rising edges, used by the bench to judge start-up counts
  initial rises = 0;
  always @(posedge osc) rises <= rises + 1;
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the clock source start-up control
`timescale 1ns/10ps
module tb;
  import csctl_pkg::*;
  localparam int MULT = 50;
  // Slow source period is 40 clocks, fast one 4 clocks
  localparam int SLOW_EC = INSTR_EDGES * 40;
  localparam int WAKE = OST_EDGES * 4 + MULT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        osc_input_pin, wake_pin, brownout_pin, sleep_req, err;
  logic        exec_hold, sysclk_run, gpio_en, osc_run, osc_slow;
  csctl_src_t  run_source;
  logic [1:0]  ext_power_level;
  logic [7:0]  periph_clk_en;
  int          rises, bad_count, total_checks, n, r0;

  // Short counts keep the run brief; expectations use the same figures
  csctl_top #(.POWER_UP_WAIT_TIMER_CYC(10), .INT_START_CYC(3), .MULT_CYC(MULT)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_input_pin(osc_input_pin),
    .wake_pin(wake_pin), .brownout_pin(brownout_pin),
    .sleep_req(sleep_req), .exec_hold(exec_hold), .sysclk_run(sysclk_run),
    .run_source(run_source), .ext_power_level(ext_power_level),
    .osc_output_gpio_en(gpio_en), .periph_clk_en(periph_clk_en));
  csctl_osc_model OSC (.run(osc_run), .slow(osc_slow),
                       .osc(osc_input_pin), .rises(rises));

  // Bit 5 has no storage, so it never reads back
  function automatic logic [31:0] exp_dis(input logic [31:0] d);
    return {24'h0, d[7:0] & ~(8'h01 << PERIPH_UNUSED_BIT)};
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic rng(input string w, input int lo, input int hi,
                     input int x);
    total_checks++;
    if (x < lo || x > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", w, lo, hi, x);
    end
  endtask

  // APB master: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  // Bounded wait on the hold flag; n returns the cycles taken
  task automatic wait_lvl(input logic l, input int lim);
    n = 0;
    while (exec_hold !== l && n < lim) begin
      @(negedge pclk);
      n++;
    end
    chk("exec_hold", l, exec_hold);
    if (exec_hold !== l) finish_test();
  endtask

  task automatic sw(input logic [31:0] c, input int lo, input int hi,
                    input csctl_src_t s);
    apb(1'b1, OSC_CTRL_OFS, c);
    wait_lvl(1'b1, 6);
    wait_lvl(1'b0, hi + 20);
    rng("switch cycles", lo, hi, n);
    chk("run_source", s, run_source);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Hang guard, well above the longest sequence
  initial begin
    #4000000;
    bad_count++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, wake_pin, brownout_pin} = '0;
    {sleep_req, osc_run, osc_slow} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'hBC1D));
    repeat (12) @(posedge pclk);
    chk("hold in reset", 1, exec_hold);
    chk("clk_en in reset", 8'hDF, periph_clk_en);
    presetn <= 1'b1;
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk("ctrl reset", {20'h0, OSC_CTRL_RST}, rd);
    apb(1'b0, PERIPH_DIS_OFS, 32'h0);
    chk("disable reset", {24'h0, PERIPH_DIS_RST}, rd);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped err", 1, err);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped read", 0, rd);
    $display("Test reset done");
    // Crystal boot: nothing is released while the pin is silent
    repeat (40) @(negedge pclk);
    chk("hold no osc", 1, exec_hold);
    r0 = rises;
    osc_run = 1'b1;
    repeat (4000) @(negedge pclk);
    chk("hold counting", 1, exec_hold);
    wait_lvl(1'b0, 400);
    rng("boot edges", OST_EDGES, OST_EDGES + 4, rises - r0);
    chk("boot source", SRC_XTAL, run_source);
    chk("clock open", 1, sysclk_run);
    $display("Test crystal boot done");
    // Random masks plus all-ones and the lone unused bit
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'hFF : (i == 1) ? 32'h20 : $urandom;
      apb(1'b1, PERIPH_DIS_OFS, v);
      apb(1'b0, PERIPH_DIS_OFS, 32'h0);
      chk("disable readback", exp_dis(v), rd);
      chk("clk_en", ~exp_dis(v) & 32'hDF, periph_clk_en);
    end
    $display("Test peripheral disable done");
    // Source changes; slow far side first, in the low band
    osc_slow = 1'b1;
    sw(32'h420, SLOW_EC - 40, SLOW_EC + 30, SRC_EXT);
    osc_slow = 1'b0;
    chk("output pin free", 1, gpio_en);
    sw(32'h421, 1, 8, SRC_SLOW);
    sw(32'h422, SWITCH_CYC - 2, SWITCH_CYC + 4, SRC_MED);
    sw(32'h421, 1, 8, SRC_SLOW);
    sw(32'h420, SLOW_PER_CYC, SLOW_PER_CYC + 16, SRC_EXT);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OSC_CTRL_OFS, {20'h0, CFG_EC_LOW + 4'(i), 8'h20});
      repeat (60) @(negedge pclk);
      chk("power level", i, ext_power_level);
    end
    sw(32'h626, 1, 8, SRC_FAST);
    chk("output pin held", 0, gpio_en);
    sw(32'h220, OST_EDGES * 4 - 8, OST_EDGES * 4 + 24, SRC_XTAL);
    $display("Test switching done");
    // Sleep with the clock stopped, then two-speed wake with multiplier
    apb(1'b1, OSC_CTRL_OFS, 32'h238);
    repeat (60) @(negedge pclk);
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("sleep gate", 0, sysclk_run);
    osc_run = 1'b0;
    repeat (30) @(negedge pclk);
    apb(1'b0, PERIPH_DIS_OFS, 32'h0);
    chk("state kept", exp_dis(v), rd);
    osc_run = 1'b1;
    @(posedge pclk);
    wake_pin <= 1'b1;
    @(posedge pclk);
    wake_pin <= 1'b0;
    r0 = rises;
    wait_lvl(1'b0, 40);
    chk("two-speed source", SRC_FAST, run_source);
    while (run_source !== SRC_XTAL && n < 6000) begin
      @(negedge pclk);
      n++;
    end
    rng("multiplier wait", WAKE - 8, WAKE + 40, n);
    rng("wake edges", OST_EDGES, OST_EDGES + 24, rises - r0);
    $display("Test sleep wake done");
    // Brown-out restarts from the power-up wait
    @(posedge pclk);
    brownout_pin <= 1'b1;
    @(posedge pclk);
    brownout_pin <= 1'b0;
    repeat (6) @(negedge pclk);
    chk("brownout hold", 1, exec_hold);
    chk("brownout gate", 0, sysclk_run);
    // Restart into the external clock input: only the short sync wait
    apb(1'b1, OSC_CTRL_OFS, 32'h420);
    r0 = rises;
    wait_lvl(1'b0, 200);
    rng("ec boot edges", INSTR_EDGES, INSTR_EDGES + 4, rises - r0);
    chk("ec boot source", SRC_EXT, run_source);
    $display("Test brownout done");
    finish_test();
  end
endmodule
